// ### hdl/imr_pkg.sv
/*
  Package of the initiator result reporter: command codes, interrupt
  cause and step values, bus phases, register offsets and the state
  and carrier structs.
  Assumes a single clock domain and an 8-bit register port.
*/
package imr_pkg;

  // ==========================================================
  // Register offsets and reset values
  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_MCOUNT = 4'h2;
  localparam logic [3:0] ADDR_MLEN   = 4'h3;
  localparam logic [3:0] ADDR_CAUSE  = 4'h4;
  localparam logic [3:0] ADDR_STEP   = 4'h5;
  localparam logic [3:0] ADDR_STAT   = 4'h6;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int         CTRL_AUTO_ACK = 0;
  localparam int         CTRL_AUTO_RX  = 1;
  localparam int         CTRL_RETRY_LSB = 4;
  localparam int         STAT_RELEASE_ACK = 0;

  // ==========================================================
  // Commands written to the command register
  typedef enum logic [1:0] {
    CMD_SEL_SINGLE_MSG = 2'b00,
    CMD_SEL_MULTI_MSG  = 2'b01,
    CMD_SEND_MULTI_MSG = 2'b10,
    CMD_SEND_MULTI_CMD = 2'b11
  } imr_cmd_e;

  // Bus phases as MSG, C/D, I/O
  localparam logic [2:0] PH_COMMAND = 3'h2;
  localparam logic [2:0] PH_STATUS  = 3'h3;
  localparam logic [2:0] PH_MSG_OUT = 3'h6;
  localparam logic [2:0] PH_MSG_IN  = 3'h7;

  // ==========================================================
  // Cause codes and step values
  localparam logic [7:0] CAUSE_RESET     = 8'h01;
  localparam logic [7:0] CAUSE_HS_TMO    = 8'h2c;
  localparam logic [7:0] CAUSE_XFER_FREE = 8'h31;
  localparam logic [7:0] CAUSE_PH_CHANGE = 8'h32;
  localparam logic [7:0] CAUSE_BAD_PHASE = 8'h54;
  localparam logic [7:0] CAUSE_RX_MSG    = 8'h55;
  localparam logic [7:0] CAUSE_RX_STATUS = 8'h56;
  localparam logic [7:0] CAUSE_DONE      = 8'h60;
  localparam logic [7:0] CAUSE_BAD_SETUP = 8'h65;
  localparam logic [7:0] CAUSE_PAUSE     = 8'h67;
  localparam logic [7:0] CAUSE_BUS_FREE  = 8'h70;
  localparam logic [7:0] CAUSE_SEL_TMO   = 8'h82;
  localparam logic [7:0] CAUSE_MSG_LONG  = 8'h65;
  localparam logic [7:0] STEP_0 = 8'h00;
  localparam logic [7:0] STEP_1 = 8'h01;
  localparam logic [7:0] STEP_2 = 8'h02;
  localparam logic [7:0] STEP_3 = 8'h03;
  localparam logic [7:0] STEP_4 = 8'h04;
  localparam logic [7:0] STEP_SEND_AUTO = 8'h0a;
  localparam logic [7:0] STEP_SEL_AUTO  = 8'h0c;
  localparam logic [7:0] MSG_LONG_LIMIT = 8'h21;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ARB   = 4'b0001,
    ST_SEL   = 4'b0010,
    ST_MSG   = 4'b0011,
    ST_CMDPH = 4'b0100,
    ST_WAIT  = 4'b0101,
    ST_XFER  = 4'b0110,
    ST_AUTRX = 4'b0111,
    ST_POST  = 4'b1000
  } imr_state_e;

  // Conditions reported by the transfer engine, one-cycle pulses
  // except phase, which is a level
  typedef struct packed {
    logic       rst_seen;
    logic       bus_free;
    logic       pause;
    logic       arb_won;
    logic       bsy_seen;
    logic       sel_tmo;
    logic       step_done;
    logic       req_first;
    logic       hs_tmo;
    logic       byte_rx;
    logic [2:0] phase;
  } imr_bus_s;

  // All state of the reporter
  typedef struct packed {
    imr_state_e st;
    imr_cmd_e   cmd;
    logic [7:0] ctrl;
    logic [7:0] mcount;
    logic [7:0] mlen;
    logic [7:0] cause;
    logic [7:0] step;
    logic [3:0] retries;
    logic [2:0] ph;
    logic       done;
    logic       irq;
    logic       atn;
    logic       ack_hold;
    logic       term;
    logic [7:0] rdata;
  } imr_state_s;

endpackage

// ### hdl/imr_reporter.sv
/*
  Result reporter for initiator select-with-message, send-message and
  send-command sequences. Tracks how far a sequence got and, on every
  ending, latches a cause code and step value and raises an interrupt.
  Assumes the transfer engine reports bus conditions synchronous to
  mclk as one-cycle pulses and acts on terminate and the ATN/ACK levels.
*/
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns

module imr_reporter #(
  parameter int RETRY_W = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire imr_pkg::imr_bus_s bus_ev,
  output logic                  busy,
  output logic                  atn_out,
  output logic                  ack_hold,
  output logic                  terminate,
  output logic                  irq
);

  // ==========================================================
  // Elaboration check
  if (RETRY_W != 4) begin : g_bad_retry
    $error("RETRY_W must be 4 to fit the control register");
  end

  imr_pkg::imr_state_s s_q;
  imr_pkg::imr_state_s s_d;

  // Close the command with a cause and step; the interrupt rises in the same cycle as terminate
  function automatic imr_pkg::imr_state_s finish(
    input imr_pkg::imr_state_s s,
    input logic [7:0]          c,
    input logic [7:0]          stp
  );
    imr_pkg::imr_state_s r;
    r = s;
    r.st = imr_pkg::ST_IDLE;
    r.cause = c;
    r.step = stp;
    r.done = 1'b1;
    r.irq = 1'b1;
    r.term = 1'b1;
    return r;
  endfunction

  // True for the two send commands
  function automatic logic is_send(input imr_pkg::imr_cmd_e c);
    return (c == imr_pkg::CMD_SEND_MULTI_MSG) || (c == imr_pkg::CMD_SEND_MULTI_CMD);
  endfunction

  // Step reached by a select sequence in a given state
  function automatic logic [7:0] sel_step(input imr_pkg::imr_state_e st);
    case (st)
      imr_pkg::ST_ARB:   sel_step = imr_pkg::STEP_1;
      imr_pkg::ST_SEL:   sel_step = imr_pkg::STEP_2;
      imr_pkg::ST_MSG:   sel_step = imr_pkg::STEP_3;
      imr_pkg::ST_CMDPH: sel_step = imr_pkg::STEP_4;
      default:           sel_step = imr_pkg::STEP_4;
    endcase
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic send;
    logic auto_ack;
    logic auto_rx;
    logic [2:0] want;
    send = 1'b0;
    auto_ack = 1'b0;
    auto_rx = 1'b0;
    want = imr_pkg::PH_MSG_OUT;
    s_d = s_q;
    s_d.term = 1'b0;
    auto_ack = s_q.ctrl[imr_pkg::CTRL_AUTO_ACK];
    auto_rx = s_q.ctrl[imr_pkg::CTRL_AUTO_RX];
    want = (s_q.cmd == imr_pkg::CMD_SEND_MULTI_CMD) ? imr_pkg::PH_COMMAND
                                                     : imr_pkg::PH_MSG_OUT;

    // Register writes; commands are only taken while idle
    if (reg_wr) begin
      case (reg_addr)
        imr_pkg::ADDR_CTRL:   s_d.ctrl = reg_wdata;
        imr_pkg::ADDR_MCOUNT: s_d.mcount = reg_wdata;
        imr_pkg::ADDR_MLEN:   s_d.mlen = reg_wdata;
        imr_pkg::ADDR_STAT: begin
          if (reg_wdata[imr_pkg::STAT_RELEASE_ACK]) s_d.ack_hold = 1'b0;
        end
        default: ;
      endcase
    end

    // Reading the cause acknowledges the interrupt
    if (reg_rd && reg_addr == imr_pkg::ADDR_CAUSE) s_d.irq = 1'b0;

    case (s_q.st)
      imr_pkg::ST_IDLE: begin
        if (reg_wr && reg_addr == imr_pkg::ADDR_CMD) begin
          s_d.cmd = imr_pkg::imr_cmd_e'(reg_wdata[1:0]);
          send = is_send(s_d.cmd);
          s_d.done = 1'b0;
          s_d.ack_hold = 1'b0;
          s_d.retries = send ? 4'h0 : s_q.ctrl[imr_pkg::CTRL_RETRY_LSB +: 4];
          if (s_q.mcount == 8'h00 && s_d.cmd != imr_pkg::CMD_SEL_SINGLE_MSG) begin
            s_d = finish(s_d, imr_pkg::CAUSE_BAD_SETUP,
                         send ? imr_pkg::STEP_1 : imr_pkg::STEP_3);
          end else if (s_d.cmd == imr_pkg::CMD_SEL_SINGLE_MSG &&
                       s_q.mlen >= imr_pkg::MSG_LONG_LIMIT) begin
            s_d = finish(s_d, imr_pkg::CAUSE_MSG_LONG, imr_pkg::STEP_3);
          end else begin
            // ATN only rises for a command that really goes to the bus
            s_d.st = send ? imr_pkg::ST_WAIT : imr_pkg::ST_ARB;
            s_d.atn = (s_d.cmd != imr_pkg::CMD_SEND_MULTI_CMD);
          end
        end
      end

      imr_pkg::ST_ARB, imr_pkg::ST_SEL, imr_pkg::ST_MSG, imr_pkg::ST_CMDPH: begin
        if (bus_ev.rst_seen) begin
          s_d = finish(s_d, imr_pkg::CAUSE_RESET, sel_step(s_q.st));
        end else if (s_q.st == imr_pkg::ST_ARB && bus_ev.pause) begin
          s_d = finish(s_d, imr_pkg::CAUSE_PAUSE, imr_pkg::STEP_1);
        end else if (s_q.st == imr_pkg::ST_ARB) begin
          if (bus_ev.arb_won) s_d.st = imr_pkg::ST_SEL;
        end else if (s_q.st == imr_pkg::ST_SEL) begin
          if (bus_ev.sel_tmo) begin
            if (s_q.retries == 4'h0) begin
              s_d = finish(s_d, imr_pkg::CAUSE_SEL_TMO, imr_pkg::STEP_2);
            end else begin
              s_d.retries = s_q.retries - 4'h1;
              s_d.st = imr_pkg::ST_ARB;
            end
          end else if (bus_ev.bsy_seen) begin
            s_d.st = imr_pkg::ST_MSG;
          end
        end else if (bus_ev.bus_free) begin
          s_d = finish(s_d, imr_pkg::CAUSE_BUS_FREE,
                       s_q.st == imr_pkg::ST_CMDPH ? imr_pkg::STEP_4 : imr_pkg::STEP_2);
        end else if (bus_ev.step_done) begin
          if (s_q.st == imr_pkg::ST_MSG) begin
            s_d.st = imr_pkg::ST_CMDPH;
            s_d.atn = 1'b0;
          end else begin
            s_d.ack_hold = !auto_ack;
            s_d = finish(s_d, imr_pkg::CAUSE_DONE,
                         auto_ack ? imr_pkg::STEP_SEL_AUTO : imr_pkg::STEP_4);
          end
        end
      end

      imr_pkg::ST_WAIT: begin
        if (bus_ev.rst_seen) begin
          s_d = finish(s_d, imr_pkg::CAUSE_RESET, imr_pkg::STEP_0);
        end else if (bus_ev.bus_free) begin
          s_d = finish(s_d, imr_pkg::CAUSE_BUS_FREE, imr_pkg::STEP_0);
        end else if (bus_ev.req_first) begin
          s_d.ph = bus_ev.phase;
          if (bus_ev.phase == want) begin
            s_d.st = imr_pkg::ST_XFER;
          end else if (auto_rx && (bus_ev.phase == imr_pkg::PH_MSG_IN ||
                                   bus_ev.phase == imr_pkg::PH_STATUS)) begin
            s_d.st = imr_pkg::ST_AUTRX;
          end else begin
            // Wrong first phase, ATN left as is
            s_d = finish(s_d, imr_pkg::CAUSE_BAD_PHASE, imr_pkg::STEP_1);
          end
        end
      end

      imr_pkg::ST_XFER, imr_pkg::ST_AUTRX: begin
        if (bus_ev.rst_seen) begin
          s_d = finish(s_d, imr_pkg::CAUSE_RESET, imr_pkg::STEP_1);
        end else if (bus_ev.hs_tmo) begin
          s_d = finish(s_d, imr_pkg::CAUSE_HS_TMO, imr_pkg::STEP_1);
        end else if (bus_ev.bus_free) begin
          s_d = finish(s_d, imr_pkg::CAUSE_XFER_FREE, imr_pkg::STEP_1);
        end else if (bus_ev.phase != s_q.ph) begin
          s_d = finish(s_d, imr_pkg::CAUSE_PH_CHANGE, imr_pkg::STEP_1);
        end else if (s_q.st == imr_pkg::ST_AUTRX && bus_ev.byte_rx) begin
          s_d.atn = 1'b0;
          s_d = finish(s_d, s_q.ph == imr_pkg::PH_MSG_IN ? imr_pkg::CAUSE_RX_MSG
                                                          : imr_pkg::CAUSE_RX_STATUS,
                       imr_pkg::STEP_1);
        end else if (s_q.st == imr_pkg::ST_XFER && bus_ev.step_done) begin
          s_d.st = imr_pkg::ST_POST;
          s_d.atn = 1'b0;
        end
      end

      imr_pkg::ST_POST: begin
        // Last ACK still on; a late reset or bus free wins over completion
        if (bus_ev.rst_seen) begin
          s_d = finish(s_d, imr_pkg::CAUSE_RESET, imr_pkg::STEP_2);
        end else if (bus_ev.bus_free) begin
          s_d = finish(s_d, imr_pkg::CAUSE_BUS_FREE, imr_pkg::STEP_2);
        end else begin
          s_d.ack_hold = !auto_ack;
          s_d = finish(s_d, imr_pkg::CAUSE_DONE,
                       auto_ack ? imr_pkg::STEP_SEND_AUTO : imr_pkg::STEP_2);
        end
      end

      default: s_d.st = imr_pkg::ST_IDLE;
    endcase

    // Read data for the cycle after a read strobe
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        imr_pkg::ADDR_CTRL:   s_d.rdata = s_q.ctrl;
        imr_pkg::ADDR_MCOUNT: s_d.rdata = s_q.mcount;
        imr_pkg::ADDR_MLEN:   s_d.rdata = s_q.mlen;
        imr_pkg::ADDR_CAUSE:  s_d.rdata = s_q.cause;
        imr_pkg::ADDR_STEP:   s_d.rdata = s_q.step;
        imr_pkg::ADDR_STAT:   s_d.rdata = {3'h0, s_q.done, s_q.atn, s_q.ack_hold,
                                           s_q.irq, s_q.st != imr_pkg::ST_IDLE};
        default:              s_d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register; irq set wins over the reading clear via finish
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: imr_pkg::ST_IDLE, cmd: imr_pkg::CMD_SEL_SINGLE_MSG,
               ctrl: imr_pkg::CTRL_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq       = s_q.irq;
  assign busy      = s_q.st != imr_pkg::ST_IDLE;
  assign atn_out   = s_q.atn;
  assign ack_hold  = s_q.ack_hold;
  assign terminate = s_q.term;

endmodule

// ### bench/imr_props.sv
/*
  Checker for the initiator result reporter, bound to its ports.
  Assumes one clock domain and the asynchronous high reset.
*/
`timescale 1ns/1ns
module imr_props #(
  parameter int RETRY_W = 4
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [3:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire imr_pkg::imr_bus_s bus_ev,
  input wire logic              busy,
  input wire logic              atn_out,
  input wire logic              ack_hold,
  input wire logic              terminate,
  input wire logic              irq
);
  // ==========================================================
  // Assertions, all on the single clock
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Read data stands one cycle only, so a stale value cannot be mistaken for fresh
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data present without a read");
  unmapped_read_a: assert property (reg_rd && reg_addr > imr_pkg::ADDR_STAT |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  irq_cause_a: assert property ($rose(irq) |-> terminate)
    else $error("interrupt raised without a command end");
  irq_hold_a: assert property (irq && !(reg_rd && reg_addr == imr_pkg::ADDR_CAUSE)
    |=> irq) else $error("interrupt dropped without cause read");
  irq_clear_a: assert property ((reg_rd && reg_addr == imr_pkg::ADDR_CAUSE) ##1
    !terminate |-> !irq) else $error("interrupt kept after cause read");
  term_pulse_a: assert property (terminate |=> !terminate)
    else $error("terminate longer than one cycle");
  term_idle_a: assert property (terminate |-> !busy)
    else $error("busy still high at terminate");
  abort_now_a: assert property (busy && (bus_ev.rst_seen || bus_ev.hs_tmo ||
    bus_ev.bus_free) |=> terminate) else $error("abort not ended at once");
  ack_rise_a: assert property ($rose(ack_hold) |-> terminate)
    else $error("ACK hold raised outside a completion");
  atn_rise_a: assert property ($rose(atn_out) |-> busy)
    else $error("ATN raised with no command");
  // Main scenarios reached
  cover property (terminate && ack_hold);
  cover property (busy && bus_ev.rst_seen);
  cover property (terminate && atn_out);
endmodule
bind imr_reporter imr_props #(.RETRY_W(RETRY_W)) u_props (.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_ev(bus_ev), .busy(busy), .atn_out(atn_out),
  .ack_hold(ack_hold), .terminate(terminate), .irq(irq));

// ### bench/imr_target.sv
/*
  Behavioural SCSI target: turns a bench event code into one-cycle bus
  condition pulses and holds the bus phase level.
  Assumes codes 1..a map to the pulse fields in struct order, b flips phase.
*/
`timescale 1ns/1ns
module imr_target (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [3:0] code,
  input  wire logic [2:0] ph,
  input  wire logic       terminate,
  output imr_pkg::imr_bus_s bus_ev
);
  logic       flip_q;
  logic [9:0] pulse;
  // One pulse per code; slow answers come from idle codes between them
  assign pulse = (code != 4'h0 && code <= 4'ha) ? (10'h200 >> (code - 4'h1)) : 10'h000;
  // Phase change holds until the command ends, as a real target would not undo it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flip_q <= 1'b0;
      bus_ev <= '0;
    end else begin
      flip_q <= (flip_q || code == 4'hb) && !terminate;
      bus_ev <= {pulse, ph ^ {2'b00, flip_q || code == 4'hb}};
    end
  end
endmodule

// ### bench/testbench.sv
/*
  Self-checking bench: table of command cases, then reset and busy cases.
  Assumes the reporter and the target model; register port as in the notes.
*/
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [1:0]  cmd;
    logic [7:0]  ctrl;
    logic [7:0]  mcnt;
    logic [7:0]  mlen;
    logic [2:0]  ph;
    logic [19:0] ev;
    logic [7:0]  cause;
    logic [7:0]  step;
    logic [1:0]  atn;
    logic        ack;
  } imr_row_s;
  logic              mclk, reset, reg_wr, reg_rd, busy, atn_out, ack_hold, terminate, irq;
  logic [3:0]        reg_addr, code;
  logic [7:0]        reg_wdata, reg_rdata, v;
  logic [2:0]        ph;
  imr_pkg::imr_bus_s bus_ev;
  int                errors, n_tests, cycles, i;
  imr_row_s          rows [26];
  // ==========================================================
  // Clock, parts and timeout
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  imr_reporter dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ev(bus_ev), .busy(busy),
    .atn_out(atn_out), .ack_hold(ack_hold), .terminate(terminate), .irq(irq));
  imr_target tgt (.mclk(mclk), .reset(reset), .code(code), .ph(ph), .terminate(terminate),
    .bus_ev(bus_ev));
  // Cuts a hang short; the whole table needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Every call ends 1 ns after an edge, so strobes may follow with no gap
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so take them there
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    d = reg_rdata;
    bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic run_row(input imr_row_s r);
    int k;
    bus(1'b1, 1'b0, imr_pkg::ADDR_CTRL, r.ctrl);
    bus(1'b1, 1'b0, imr_pkg::ADDR_MCOUNT, r.mcnt);
    bus(1'b1, 1'b0, imr_pkg::ADDR_MLEN, r.mlen);
    ph <= r.ph;
    bus(1'b1, 1'b0, imr_pkg::ADDR_CMD, {6'h00, r.cmd});
    reg_wr <= 1'b0;
    // Target events, one slot per cycle, zero slots act as target delay
    for (k = 4; k >= 0; k--) begin
      code <= r.ev[k*4 +: 4];
      @(posedge mclk);
      #1;
    end
    code <= 4'h0;
    for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge mclk);
    #1;
    chk("irq_set", 8'h01, {7'h00, irq});
    chk("busy_end", 8'h00, {7'h00, busy});
    chk("ack_hold", {7'h00, r.ack}, {7'h00, ack_hold});
    if (r.atn[1]) chk("atn", {7'h00, r.atn[0]}, {7'h00, atn_out});
    rd(imr_pkg::ADDR_CAUSE, v);
    chk("cause", r.cause, v);
    rd(imr_pkg::ADDR_STEP, v);
    chk("step", r.step, v);
    chk("irq_clr", 8'h00, {7'h00, irq});
    rd(imr_pkg::ADDR_MLEN, v);
    chk("mlen", r.mlen, v);
    bus(1'b1, 1'b0, imr_pkg::ADDR_STAT, 8'h01);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, code, ph} = '0;
    {errors, n_tests, cycles} = '0;
    // Codes: 1 rst 2 free 3 pause 4 arb 5 bsy 6 tmo 7 done 8 req 9 hs a rx b flip
    rows = '{
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h6, 20'h80700, 8'h60, 8'h02, 2'b10, 1'b1},
      '{2'h2, 8'h01, 8'h01, 8'h04, 3'h6, 20'h80700, 8'h60, 8'h0a, 2'b10, 1'b0},
      '{2'h3, 8'h00, 8'h01, 8'h04, 3'h2, 20'h80700, 8'h60, 8'h02, 2'b00, 1'b1},
      '{2'h3, 8'h01, 8'h01, 8'h04, 3'h2, 20'h80700, 8'h60, 8'h0a, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h00, 8'h04, 3'h6, 20'h00000, 8'h65, 8'h01, 2'b00, 1'b0},
      '{2'h3, 8'h00, 8'h00, 8'h04, 3'h2, 20'h00000, 8'h65, 8'h01, 2'b00, 1'b0},
      '{2'h1, 8'h00, 8'h00, 8'h04, 3'h6, 20'h00000, 8'h65, 8'h03, 2'b00, 1'b0},
      '{2'h0, 8'h00, 8'h01, 8'h21, 3'h6, 20'h00000, 8'h65, 8'h03, 2'b00, 1'b0},
      '{2'h0, 8'h00, 8'h01, 8'h20, 3'h6, 20'h30000, 8'h67, 8'h01, 2'b00, 1'b0},
      '{2'h1, 8'h00, 8'h01, 8'h04, 3'h6, 20'h45200, 8'h70, 8'h02, 2'b00, 1'b0},
      '{2'h1, 8'h00, 8'h01, 8'h04, 3'h6, 20'h45720, 8'h70, 8'h04, 2'b00, 1'b0},
      '{2'h1, 8'h00, 8'h01, 8'h04, 3'h6, 20'h45770, 8'h60, 8'h04, 2'b00, 1'b1},
      '{2'h1, 8'h10, 8'h01, 8'h04, 3'h6, 20'h46460, 8'h82, 8'h02, 2'b00, 1'b0},
      '{2'h1, 8'h20, 8'h01, 8'h04, 3'h6, 20'h46463, 8'h67, 8'h01, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h6, 20'h10000, 8'h01, 8'h00, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h6, 20'h81000, 8'h01, 8'h01, 2'b00, 1'b0},
      '{2'h3, 8'h00, 8'h01, 8'h04, 3'h2, 20'h80710, 8'h01, 8'h02, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h6, 20'h89000, 8'h2c, 8'h01, 2'b00, 1'b0},
      '{2'h3, 8'h00, 8'h01, 8'h04, 3'h2, 20'h82000, 8'h31, 8'h01, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h6, 20'h8b000, 8'h32, 8'h01, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h3, 20'h80000, 8'h54, 8'h01, 2'b11, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h7, 20'h8a000, 8'h54, 8'h01, 2'b11, 1'b0},
      '{2'h2, 8'h02, 8'h01, 8'h04, 3'h7, 20'h8a000, 8'h55, 8'h01, 2'b10, 1'b0},
      '{2'h3, 8'h02, 8'h01, 8'h04, 3'h3, 20'h8a000, 8'h56, 8'h01, 2'b10, 1'b0},
      '{2'h3, 8'h00, 8'h01, 8'h04, 3'h6, 20'h80000, 8'h54, 8'h01, 2'b00, 1'b0},
      '{2'h2, 8'h00, 8'h01, 8'h04, 3'h6, 20'h20000, 8'h70, 8'h00, 2'b00, 1'b0}};
    reset = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    reset = 1'b0;
    rd(imr_pkg::ADDR_CTRL, v);
    chk("ctrl_reset", imr_pkg::CTRL_RESET, v);
    rd(4'hf, v);
    chk("unmapped", 8'h00, v);
    for (i = 0; i < 26; i++) run_row(rows[i]);
    run_row('{2'h3, 8'h00, 8'h01, 8'h04, 3'h2, 20'h80720, 8'h70, 8'h02, 2'b00, 1'b0});
    // A second command while busy is ignored: send-message phase still accepted
    bus(1'b1, 1'b0, imr_pkg::ADDR_CMD, 8'h02);
    run_row('{2'h3, 8'h00, 8'h01, 8'h04, 3'h6, 20'h80700, 8'h60, 8'h02, 2'b10, 1'b1});
    chk("ack_release", 8'h00, {7'h00, ack_hold});
    // Reset in mid-command clears every output
    bus(1'b1, 1'b0, imr_pkg::ADDR_CMD, 8'h02);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    reset = 1'b1;
    @(posedge mclk);
    #1;
    chk("outs_in_reset", 8'h00, {3'h0, busy, atn_out, ack_hold, terminate, irq});
    reset = 1'b0;
    run_row(rows[0]);
    end_sim();
  end
endmodule
